// [common/pscp_pkg.sv]
// Purpose: shared constants for the status/command parity block
// Assumes: 32-bit classic wishbone register access
// Notes: bit positions follow the combined status/command word
package pscp_pkg;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam int PSCP_ADR_MIN = 4;
    localparam logic [3:0] PSCP_OFS_STATCMD = 4'h0;
    localparam logic [3:0] PSCP_OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0] PSCP_OFS_IRQ_MASK = 4'h8;

    // ----------------------------------------
    // status/command field positions
    // ----------------------------------------
    localparam int PSCP_BIT_DET_PAR = 31;
    localparam int PSCP_BIT_INIT_PAR = 24;
    localparam int PSCP_BIT_B2B_TGT = 23;
    localparam int PSCP_BIT_HIGH_SPD = 21;
    localparam int PSCP_BIT_CAP_LIST = 20;
    localparam int PSCP_BIT_B2B_EN = 9;
    localparam int PSCP_BIT_SYSERR_EN = 8;
    localparam int PSCP_BIT_STEPPING = 7;
    localparam int PSCP_BIT_PAR_RSP = 6;
    localparam int PSCP_BIT_PALETTE = 5;

    // ----------------------------------------
    // fixed and reset values
    // ----------------------------------------
    localparam logic PSCP_VAL_B2B_TGT = 1'b1;
    localparam logic PSCP_VAL_HIGH_SPD = 1'b1;
    localparam logic PSCP_VAL_CAP_LIST = 1'b1;
    localparam logic PSCP_VAL_STEPPING = 1'b0;
    localparam logic PSCP_VAL_PALETTE = 1'b0;
    localparam logic PSCP_RST_CTL = 1'b0;
    localparam logic PSCP_PIN_IDLE = 1'b1;

    // ----------------------------------------
    // interrupt sources
    // ----------------------------------------
    localparam int PSCP_IRQ_W = 3;
    localparam int PSCP_IRQ_INIT_PAR = 0;
    localparam int PSCP_IRQ_DET_PAR = 1;
    localparam int PSCP_IRQ_SYSERR = 2;

    // ----------------------------------------
    // parity error pin sequence
    // ----------------------------------------
    typedef enum logic [1:0] {
        PSCP_PERR_IDLE = 2'b00,
        PSCP_PERR_LOW = 2'b01,
        PSCP_PERR_HIGH = 2'b10
    } pscp_perr_e;

endpackage : pscp_pkg

// [rtl/pscp_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pin is asynchronous to clk_sys
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pscp_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // pin and filtered level
    input wire logic pin_in,
    output logic level_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } pscp_sync_s;

    pscp_sync_s sync_reg;
    pscp_sync_s sync_next;

    // stage one feeds only stage two
    always_comb begin
        sync_next = sync_reg;
        sync_next.s1 = pin_in;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        if (sync_reg.s2 == sync_reg.s3) begin
            sync_next.lvl = sync_reg.s3;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync_reg <= {4{RESET_VAL}};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign level_out = sync_reg.lvl;

endmodule : pscp_sync
`default_nettype wire

// [rtl/pscp_irq.sv]
// Purpose: sticky event status, mask and level interrupt
// Assumes: clear and mask writes are single-cycle strobes
// Notes: a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none
module pscp_irq #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // events
    input wire logic [W-1:0] evt,
    // software access
    input wire logic clr_wr,
    input wire logic mask_wr,
    input wire logic [W-1:0] wr_dat,
    // state
    output logic [W-1:0] status,
    output logic [W-1:0] mask,
    output logic irq
);

    typedef struct packed {
        logic [W-1:0] status;
        logic [W-1:0] mask;
        logic irq;
    } pscp_irq_s;

    pscp_irq_s irq_reg;
    pscp_irq_s irq_next;
    logic [W-1:0] stat_nx;

    generate
        if (W < 1) begin : g_bad
            $error("pscp_irq: W must be at least 1");
        end
        for (genvar i = 0; i < W; i++) begin : g_bit
            assign stat_nx[i] = evt[i] |
                (irq_reg.status[i] & ~(clr_wr & wr_dat[i]));
        end
    endgenerate

    always_comb begin
        irq_next = irq_reg;
        irq_next.status = stat_nx;
        if (mask_wr) begin
            irq_next.mask = wr_dat;
        end
        // level follows the registered status one cycle later
        irq_next.irq = |(irq_reg.status & irq_reg.mask);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign status = irq_reg.status;
    assign mask = irq_reg.mask;
    assign irq = irq_reg.irq;

endmodule : pscp_irq
`default_nettype wire

// [rtl/pscp_top.sv]
// Purpose: status/command word bits 31 and 24..5 with parity gating
// Assumes: event strobes come from pci core logic on clk_sys
// Notes: perr/serr pins are driven through output enables
//
// Contract
// - initiator parity flag sets only while we master, never as target
// - it sets on perr seen, we mastered, and parity response enabled
// - initiator parity flag resets to zero, write one clears it
// - bit 23 reads one, read-only, back-to-back target capable
// - bit 21 reads one, read-only, high speed capable
// - bit 20 reads one, read-only, capability list present
// - bit 9 read-write, reset zero, allows back-to-back issue
// - bit 8 read-write, reset zero, enables system error pin
// - system error driven only with both its enable and parity enable
// - system error reports address or special cycle data parity
// - bit 7 reads zero, read-only, no stepping control
// - bit 6 read-write, reset zero, parity response enable
// - perr or serr asserted only while parity response enabled
// - parity response off stops perr and serr, but bit 31 still sets
// - bit 5 reads zero, read-only, no palette snooping
// - detected parity flag sets on every data or address parity error regardless; spc_par_err alone does not set it
`timescale 1ns/1ps
`default_nettype none
module pscp_top
    import pscp_pkg::*;
#(
    parameter int ADR_W = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // parity events from the pci core
    input wire logic init_xfer,
    input wire logic data_par_err,
    input wire logic addr_par_err,
    input wire logic spc_par_err,
    // perr pin, s/t/s
    input wire logic perr_n_i,
    output logic perr_n_o,
    output logic perr_n_oe_n,
    // serr pin, open drain
    output logic serr_n_o,
    output logic serr_n_oe_n,
    // enables towards the pci core
    output logic b2b_issue_enable,
    output logic parity_response_enable,
    output logic system_error_enable,
    // interrupt
    output logic irq
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    generate
        if (ADR_W < PSCP_ADR_MIN) begin : g_bad
            $error("pscp_top: ADR_W too small for the map");
        end
    endgenerate

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic b2b_en;
        logic syserr_en;
        logic par_rsp;
        logic init_par;
        logic det_par;
        pscp_perr_e perr_ph;
        logic perr_o;
        logic perr_oe_n;
        logic serr_oe_n;
        logic perr_prev;
    } pscp_state_s;

    pscp_state_s st_reg;
    pscp_state_s st_next;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic adr_hit(
        input logic [ADR_W-1:0] adr,
        input logic [3:0] ofs
    );
        logic [ADR_W-1:0] full;
        full = '0;
        full[3:0] = ofs;
        adr_hit = (adr[ADR_W-1:2] == full[ADR_W-1:2]);
    endfunction : adr_hit

    // builds the visible status/command word
    function automatic logic [31:0] statcmd_word(
        input pscp_state_s s
    );
        logic [31:0] w;
        w = '0;
        w[PSCP_BIT_DET_PAR] = s.det_par;
        w[PSCP_BIT_INIT_PAR] = s.init_par;
        w[PSCP_BIT_B2B_TGT] = PSCP_VAL_B2B_TGT;
        w[PSCP_BIT_HIGH_SPD] = PSCP_VAL_HIGH_SPD;
        w[PSCP_BIT_CAP_LIST] = PSCP_VAL_CAP_LIST;
        w[PSCP_BIT_B2B_EN] = s.b2b_en;
        w[PSCP_BIT_SYSERR_EN] = s.syserr_en;
        w[PSCP_BIT_STEPPING] = PSCP_VAL_STEPPING;
        w[PSCP_BIT_PAR_RSP] = s.par_rsp;
        w[PSCP_BIT_PALETTE] = PSCP_VAL_PALETTE;
        statcmd_word = w;
    endfunction : statcmd_word

    // ----------------------------------------
    // perr pin synchroniser
    // ----------------------------------------
    logic perr_lvl;

    pscp_sync #(
        .RESET_VAL(PSCP_PIN_IDLE)
    ) u_perr_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in(perr_n_i),
        .level_out(perr_lvl)
    );

    // ----------------------------------------
    // interrupt block
    // ----------------------------------------
    logic [PSCP_IRQ_W-1:0] irq_evt;
    logic [PSCP_IRQ_W-1:0] irq_stat;
    logic [PSCP_IRQ_W-1:0] irq_mask;
    logic irq_clr_wr;
    logic irq_mask_wr;

    pscp_irq #(
        .W(PSCP_IRQ_W)
    ) u_irq (
        .clk_sys(clk_sys),
        .reset(reset),
        .evt(irq_evt),
        .clr_wr(irq_clr_wr),
        .mask_wr(irq_mask_wr),
        .wr_dat(wb_dat_i[PSCP_IRQ_W-1:0]),
        .status(irq_stat),
        .mask(irq_mask),
        .irq(irq)
    );

    // ----------------------------------------
    // bus request decode
    // ----------------------------------------
    logic req;
    logic wr;
    logic hit_sc;
    logic hit_is;
    logic hit_im;
    logic wr_sc;

    assign req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    assign wr = req & wb_we_i;
    assign hit_sc = adr_hit(wb_adr_i, PSCP_OFS_STATCMD);
    assign hit_is = adr_hit(wb_adr_i, PSCP_OFS_IRQ_STAT);
    assign hit_im = adr_hit(wb_adr_i, PSCP_OFS_IRQ_MASK);
    assign wr_sc = wr & hit_sc;
    assign irq_clr_wr = wr & hit_is & wb_sel_i[0];
    assign irq_mask_wr = wr & hit_im & wb_sel_i[0];

    // ----------------------------------------
    // parity events
    // ----------------------------------------
    logic perr_fall;
    logic perr_start;
    logic init_set;
    logic det_set;
    logic serr_start;
    logic init_clr;
    logic det_clr;

    // perr seen low on the bus, driven by anyone
    assign perr_fall = st_reg.perr_prev & ~perr_lvl;

    // we report a data parity error ourselves
    assign perr_start = data_par_err & st_reg.par_rsp;

    // own perr counts as the indirect case
    assign init_set = st_reg.par_rsp & init_xfer &
        (perr_fall | perr_start);

    // bit 31 ignores the response enable
    assign det_set = data_par_err | addr_par_err;

    // address or special cycle parity only
    assign serr_start = (addr_par_err | spc_par_err) &
        st_reg.syserr_en & st_reg.par_rsp;

    assign init_clr = wr_sc & wb_sel_i[3] &
        wb_dat_i[PSCP_BIT_INIT_PAR];
    assign det_clr = wr_sc & wb_sel_i[3] &
        wb_dat_i[PSCP_BIT_DET_PAR];

    always_comb begin
        irq_evt = '0;
        irq_evt[PSCP_IRQ_INIT_PAR] = init_set;
        irq_evt[PSCP_IRQ_DET_PAR] = det_set;
        irq_evt[PSCP_IRQ_SYSERR] = serr_start;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.perr_prev = perr_lvl;

        // wishbone: one wait state, ack for every address
        st_next.ack = req;
        st_next.dat = '0;
        if (req & ~wb_we_i) begin
            if (hit_sc) begin
                st_next.dat = statcmd_word(st_reg);
            end else if (hit_is) begin
                st_next.dat[PSCP_IRQ_W-1:0] = irq_stat;
            end else if (hit_im) begin
                st_next.dat[PSCP_IRQ_W-1:0] = irq_mask;
            end
        end

        // only the three enables take written data
        if (wr_sc & wb_sel_i[1]) begin
            st_next.b2b_en = wb_dat_i[PSCP_BIT_B2B_EN];
            st_next.syserr_en = wb_dat_i[PSCP_BIT_SYSERR_EN];
        end
        if (wr_sc & wb_sel_i[0]) begin
            st_next.par_rsp = wb_dat_i[PSCP_BIT_PAR_RSP];
        end

        // sticky flags, a set beats a clear in the same cycle
        st_next.init_par = init_set |
            (st_reg.init_par & ~init_clr);
        st_next.det_par = det_set |
            (st_reg.det_par & ~det_clr);

        // perr: drive low, drive high one clock, then release
        case (st_reg.perr_ph)
            PSCP_PERR_IDLE: begin
                if (perr_start) begin
                    st_next.perr_ph = PSCP_PERR_LOW;
                end
            end
            PSCP_PERR_LOW: begin
                if (!perr_start) begin
                    st_next.perr_ph = PSCP_PERR_HIGH;
                end
            end
            PSCP_PERR_HIGH: begin
                if (perr_start) begin
                    st_next.perr_ph = PSCP_PERR_LOW;
                end else begin
                    st_next.perr_ph = PSCP_PERR_IDLE;
                end
            end
            default: begin
                st_next.perr_ph = PSCP_PERR_IDLE;
            end
        endcase

        case (st_next.perr_ph)
            PSCP_PERR_LOW: begin
                st_next.perr_o = 1'b0;
                st_next.perr_oe_n = 1'b0;
            end
            PSCP_PERR_HIGH: begin
                st_next.perr_o = PSCP_PIN_IDLE;
                st_next.perr_oe_n = 1'b0;
            end
            default: begin
                st_next.perr_o = PSCP_PIN_IDLE;
                st_next.perr_oe_n = 1'b1;
            end
        endcase

        // serr is open drain: pull low one clock, never drive high
        st_next.serr_oe_n = ~serr_start;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.b2b_en <= PSCP_RST_CTL;
            st_reg.syserr_en <= PSCP_RST_CTL;
            st_reg.par_rsp <= PSCP_RST_CTL;
            st_reg.perr_ph <= PSCP_PERR_IDLE;
            st_reg.perr_o <= PSCP_PIN_IDLE;
            st_reg.perr_oe_n <= 1'b1;
            st_reg.serr_oe_n <= 1'b1;
            st_reg.perr_prev <= PSCP_PIN_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.dat;
    assign perr_n_o = st_reg.perr_o;
    assign perr_n_oe_n = st_reg.perr_oe_n;
    // level driven while enabled is always low
    assign serr_n_o = st_reg.serr_oe_n & 1'b0;
    assign serr_n_oe_n = st_reg.serr_oe_n;
    assign b2b_issue_enable = st_reg.b2b_en;
    assign parity_response_enable = st_reg.par_rsp;
    assign system_error_enable = st_reg.syserr_en;

endmodule : pscp_top
`default_nettype wire

// [test/pscp_monitor.sv]
// Purpose: port checks for the status/command parity block
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto pscp_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pscp_monitor
    import pscp_pkg::*;
#(
    parameter int ADR_W = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // events and pins
    input wire logic data_par_err,
    input wire logic addr_par_err,
    input wire logic spc_par_err,
    input wire logic perr_n_o,
    input wire logic perr_n_oe_n,
    input wire logic serr_n_oe_n,
    // enables and interrupt
    input wire logic parity_response_enable,
    input wire logic system_error_enable,
    input wire logic irq
);
    // fixed bits of the word: mask and the value they must read
    localparam logic [31:0] FIX_M = 32'h7efffcbf;
    localparam logic [31:0] FIX_V = 32'h00b00000;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    property p_ack_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_take: assert property (p_ack_take)
        else $error("ack not a one-cycle answer");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data not zero outside ack");
    property p_fixed;
        wb_ack_o && !wb_we_i && (wb_adr_i >> 2) == 0
            |-> (wb_dat_o & FIX_M) == FIX_V;
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed bits of status word wrong");
    property p_serr_gate;
        !serr_n_oe_n |-> $past(system_error_enable && parity_response_enable);
    endproperty
    a_serr_gate: assert property (p_serr_gate)
        else $error("serr driven without both enables");
    property p_serr_cause;
        !serr_n_oe_n |-> $past(addr_par_err || spc_par_err);
    endproperty
    a_serr_cause: assert property (p_serr_cause)
        else $error("serr driven without a qualifying error");
    property p_serr_fire;
        (addr_par_err || spc_par_err) && system_error_enable
            && parity_response_enable |=> !serr_n_oe_n;
    endproperty
    a_serr_fire: assert property (p_serr_fire)
        else $error("serr not driven");
    property p_perr_gate;
        $fell(perr_n_oe_n) |-> $past(data_par_err && parity_response_enable);
    endproperty
    a_perr_gate: assert property (p_perr_gate)
        else $error("perr driven without enabled cause");
    property p_perr_drive;
        data_par_err && parity_response_enable |=> !perr_n_oe_n && !perr_n_o;
    endproperty
    a_perr_drive: assert property (p_perr_drive)
        else $error("perr not driven low");
    property p_perr_free;
        !perr_n_oe_n && perr_n_o && !data_par_err |=> perr_n_oe_n;
    endproperty
    a_perr_free: assert property (p_perr_free)
        else $error("perr not released after high cycle");
    c_serr: cover property (!serr_n_oe_n);
    c_perr: cover property ($fell(perr_n_oe_n));
    c_irq: cover property ($rose(irq));
endmodule : pscp_monitor
bind pscp_top pscp_monitor #(.ADR_W(ADR_W)) i_pscp_monitor (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
    .data_par_err(data_par_err), .addr_par_err(addr_par_err),
    .spc_par_err(spc_par_err), .perr_n_o(perr_n_o),
    .perr_n_oe_n(perr_n_oe_n), .serr_n_oe_n(serr_n_oe_n),
    .parity_response_enable(parity_response_enable),
    .system_error_enable(system_error_enable)
);
`default_nettype wire

// [test/pscp_pci_agent.sv]
// Purpose: other pci agents sharing the perr and serr lines
// Assumes: both lines carry pull-ups
// Notes: agent_perr makes another agent pull perr low
`timescale 1ns/1ps
`default_nettype none
module pscp_pci_agent (
    // design pin drives
    input wire logic perr_n_o,
    input wire logic perr_n_oe_n,
    input wire logic serr_n_o,
    input wire logic serr_n_oe_n,
    // bench command
    input wire logic agent_perr,
    // resolved wire levels
    output logic perr_n,
    output logic serr_n
);
    // released lines float back to the pull-up level, never a stale value
    always_comb begin
        perr_n = (perr_n_oe_n ? 1'b1 : perr_n_o) & ~agent_perr;
        serr_n = serr_n_oe_n ? 1'b1 : serr_n_o;
    end
endmodule : pscp_pci_agent
`default_nettype wire

// [test/pci_status_command_parity_tb_top.sv]
// Purpose: directed bench for the status/command parity block
// Assumes: wishbone answer comes the cycle after a request
// Notes: the pin model resolves perr and serr with pull-ups
`timescale 1ns/1ps
`default_nettype none
module pci_status_command_parity_tb_top;
    import pscp_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic init_xfer = 1'b0;
    logic data_par_err = 1'b0;
    logic addr_par_err = 1'b0;
    logic spc_par_err = 1'b0;
    logic agent_perr = 1'b0;
    logic perr_n, perr_n_o, perr_n_oe_n, serr_n, serr_n_o, serr_n_oe_n;
    logic b2b_en, par_en, sys_en, irq;
    int n_fail = 0;
    int compares = 0;
    pscp_top #(.ADR_W(4)) i_pscp_top (
        .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .init_xfer(init_xfer),
        .data_par_err(data_par_err), .addr_par_err(addr_par_err),
        .spc_par_err(spc_par_err), .perr_n_i(perr_n),
        .perr_n_o(perr_n_o), .perr_n_oe_n(perr_n_oe_n),
        .serr_n_o(serr_n_o), .serr_n_oe_n(serr_n_oe_n),
        .b2b_issue_enable(b2b_en), .parity_response_enable(par_en),
        .system_error_enable(sys_en), .irq(irq)
    );
    pscp_pci_agent i_pscp_pci_agent (
        .perr_n_o(perr_n_o), .perr_n_oe_n(perr_n_oe_n),
        .serr_n_o(serr_n_o), .serr_n_oe_n(serr_n_oe_n),
        .agent_perr(agent_perr), .perr_n(perr_n), .serr_n(serr_n)
    );
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic cmp1(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask : cmp1
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic xfer(input logic [3:0] a, input logic we,
                        input logic [3:0] s, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
        n = 0;
        do begin
            tick;
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            n_fail++;
            $display("unexpected ack: expected 1 seen %b", wb_ack_o);
            close_out;
        end
        q = wb_dat_o;
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : xfer
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [31:0] q;
        xfer(a, 1'b1, s, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input string nm);
        logic [31:0] q;
        xfer(a, 1'b0, 4'hf, 32'h0, q);
        cmp(nm, e, q);
    endtask : rd
    // ev is {init_xfer, data, address, special cycle} for one cycle
    task automatic pulse(input logic [3:0] ev);
        @(posedge clk_sys);
        {init_xfer, data_par_err, addr_par_err, spc_par_err} <= ev;
        @(posedge clk_sys);
        {init_xfer, data_par_err, addr_par_err, spc_par_err} <= 4'h0;
        #1;
    endtask : pulse
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(4'h0, 32'h00b00000, "statcmd");
        cmp1("irq", 1'b0, irq);
        $display("test reset done");
    endtask : t_reset
    task automatic t_ctl;
        wr(4'h0, 32'hffffffff, 4'hf);
        rd(4'h0, 32'h00b00340, "statcmd");
        cmp1("b2b", 1'b1, b2b_en);
        wr(4'h0, 32'h0, 4'hf);
        rd(4'h0, 32'h00b00000, "statcmd");
        cmp1("syserr", 1'b0, sys_en);
        wr(4'h0, 32'h340, 4'h1);
        rd(4'h0, 32'h00b00040, "statcmd");
        wr(4'h0, 32'h340, 4'h3);
        cmp1("parity", 1'b1, par_en);
        $display("test control done");
    endtask : t_ctl
    task automatic t_init;
        pulse(4'b0100);
        cmp1("perr", 1'b0, perr_n);
        tick;
        cmp1("perr", 1'b1, perr_n);
        cmp1("perr_oe", 1'b0, perr_n_oe_n);
        tick;
        cmp1("perr_oe", 1'b1, perr_n_oe_n);
        rd(4'h0, 32'h80b00340, "statcmd");
        pulse(4'b1100);
        cmp1("serr", 1'b1, serr_n);
        rd(4'h0, 32'h81b00340, "statcmd");
        wr(4'h0, 32'h0, 4'h8);
        rd(4'h0, 32'h81b00340, "statcmd");
        wr(4'h0, 32'h81000000, 4'h8);
        rd(4'h0, 32'h00b00340, "statcmd");
        $display("test initiator done");
    endtask : t_init
    task automatic t_serr;
        pulse(4'b0010);
        cmp1("serr", 1'b0, serr_n);
        tick;
        cmp1("serr", 1'b1, serr_n);
        pulse(4'b0001);
        cmp1("serr", 1'b0, serr_n);
        wr(4'h0, 32'h40, 4'h3);
        pulse(4'b0010);
        cmp1("serr", 1'b1, serr_n);
        rd(4'h0, 32'h80b00040, "statcmd");
        $display("test serr done");
    endtask : t_serr
    task automatic t_off;
        wr(4'h0, 32'h80000100, 4'hb);
        pulse(4'b1110);
        cmp1("perr", 1'b1, perr_n);
        cmp1("serr", 1'b1, serr_n);
        rd(4'h0, 32'h80b00100, "statcmd");
        wr(4'h0, 32'h80000340, 4'hb);
        $display("test parity off done");
    endtask : t_off
    task automatic t_ext;
        @(posedge clk_sys);
        agent_perr <= 1'b1;
        repeat (4) @(posedge clk_sys);
        agent_perr <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rd(4'h0, 32'h00b00340, "statcmd");
        @(posedge clk_sys);
        {init_xfer, agent_perr} <= 2'b11;
        repeat (4) @(posedge clk_sys);
        agent_perr <= 1'b0;
        repeat (8) @(posedge clk_sys);
        init_xfer <= 1'b0;
        rd(4'h0, 32'h01b00340, "statcmd");
        wr(4'h0, 32'h01000000, 4'h8);
        $display("test external perr done");
    endtask : t_ext
    task automatic t_irq;
        wr(4'h4, 32'h7, 4'h1);
        rd(4'h4, 32'h0, "irq_stat");
        pulse(4'b1110);
        tick;
        tick;
        cmp1("irq", 1'b0, irq);
        rd(4'h4, 32'h7, "irq_stat");
        wr(4'h8, 32'h2, 4'h1);
        tick;
        cmp1("irq", 1'b1, irq);
        rd(4'h8, 32'h2, "irq_mask");
        wr(4'h4, 32'h5, 4'h1);
        tick;
        cmp1("irq", 1'b1, irq);
        wr(4'h4, 32'h2, 4'h1);
        tick;
        cmp1("irq", 1'b0, irq);
        wr(4'hc, 32'hffffffff, 4'hf);
        rd(4'hc, 32'h0, "unmapped");
        $display("test interrupt done");
    endtask : t_irq
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset;
        t_ctl;
        t_init;
        t_serr;
        t_off;
        t_ext;
        t_irq;
        close_out;
    end
endmodule : pci_status_command_parity_tb_top
`default_nettype wire
